/* lpm_cfg.svh */
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH

`define LPM_F_R1_KHZ   16'h7D00
`define LPM_F_R2_KHZ   16'h3E80
`define LPM_F_R3_KHZ   16'h1068
`define LPM_F_LP_KHZ   16'h0083
`define LPM_WAKE_NS    3500
`define LPM_CLK_NS     4
`define LPM_WAKE_PIPE  4
`define LPM_WAKE_CYC   (`LPM_WAKE_NS / `LPM_CLK_NS)
`define LPM_RST_RANGE  2'h1
`define LPM_RST_FREQ   16'h0000

`endif

/* lpm_pkg.sv */
package lpm_pkg;

    typedef enum logic [2:0] {
        LPM_REQ_RUN     = 3'h0,
        LPM_REQ_SLEEP   = 3'h1,
        LPM_REQ_LPRUN   = 3'h2,
        LPM_REQ_LPSLEEP = 3'h3,
        LPM_REQ_STOP    = 3'h4
    } lpm_mode_e;

    typedef enum logic [5:0] {
        LPM_ST_RUN     = 6'h01,
        LPM_ST_SLEEP   = 6'h02,
        LPM_ST_LPRUN   = 6'h04,
        LPM_ST_LPSLEEP = 6'h08,
        LPM_ST_STOP    = 6'h10,
        LPM_ST_WAKE    = 6'h20
    } lpm_state_e;

    typedef enum logic [1:0] {
        LPM_SRC_PIN  = 2'h0,
        LPM_SRC_SVD  = 2'h1,
        LPM_SRC_CMP1 = 2'h2,
        LPM_SRC_CMP2 = 2'h3
    } lpm_src_e;

    typedef struct packed {
        logic pll_en;
        logic multispeed_internal_osc_en;
        logic multispeed_internal_osc_low;
        logic high_speed_external_osc_en;
        logic high_speed_internal_osc_en;
        logic low_speed_external_osc_en;
        logic low_speed_internal_osc_en;
    } lpm_osc_s;

    typedef struct packed {
        logic cpu_clk_en;
        logic core_clk_en;
        logic regulator_lp;
        logic retain;
    } lpm_pwr_s;

endpackage

/* lpm_wake_sel.sv */
`timescale 1ns/1ps
`default_nettype none
module lpm_wake_sel
#(
    parameter int N = 8
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            arst_n,
    // asynchronous sources
    input  wire logic [N-1:0]    gpio_pin,
    input  wire logic            supply_voltage_detector,
    input  wire logic            comp1_evt,
    input  wire logic            comp2_evt,
    // per line selection
    input  wire lpm_pkg::lpm_src_e [N-1:0] src_sel,
    input  wire logic [N-1:0]    line_en,
    // synchronised wake lines
    output logic [N-1:0]         external_wake_line
);
    import lpm_pkg::*;
    localparam int W = N + 3;
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [N-1:0] next_line;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            sync <= '0;
        end else begin
            meta <= {comp2_evt, comp1_evt, supply_voltage_detector, gpio_pin};
            sync <= meta;
        end
    end

    for (genvar i = 0; i < N; i++) begin : g_line
        wire pick = (src_sel[i] == LPM_SRC_PIN)  ? sync[i]   :
                    (src_sel[i] == LPM_SRC_SVD)  ? sync[N]   :
                    (src_sel[i] == LPM_SRC_CMP1) ? sync[N+1] :
                                                   sync[N+2];
        assign next_line[i] = pick & line_en[i];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            external_wake_line <= '0;
        end else begin
            external_wake_line <= next_line;
        end
    end
endmodule
`default_nettype wire

/* lpm_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"
module lpm_ctrl
#(
    parameter int N = 8
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                arst_n,
    // processor requests
    input  wire lpm_pkg::lpm_mode_e  mode_req,
    input  wire logic                wfi,
    input  wire logic                wfe,
    input  wire logic                irq_pending,
    input  wire logic                event_in,
    input  wire logic [1:0]          range_sel,
    input  wire logic [15:0]         req_freq_khz,
    input  wire logic                low_speed_ext_sel,
    // wake-up sources
    input  wire logic [N-1:0]        gpio_pin,
    input  wire logic                supply_voltage_detector,
    input  wire logic                comp1_evt,
    input  wire logic                comp2_evt,
    input  wire lpm_pkg::lpm_src_e [N-1:0] src_sel,
    input  wire logic [N-1:0]        line_en,
    input  wire logic                hsi_req,
    input  wire logic                osc_ready,
    // controls and status
    output lpm_pkg::lpm_osc_s        osc,
    output lpm_pkg::lpm_pwr_s        pwr,
    output lpm_pkg::lpm_state_e      state,
    output logic [15:0]              cpu_freq_khz,
    output logic [N-1:0]             wake_lines
);
    import lpm_pkg::*;
    // pin synchroniser and line select eat part of the wake budget
    localparam logic [9:0] WAKE_LAST =
        10'(`LPM_WAKE_CYC - `LPM_WAKE_PIPE - 1);

    lpm_state_e  next_state;
    logic [9:0]  wake_cnt;
    logic [9:0]  next_wake_cnt;
    logic [1:0]  hsi_meta;
    logic [1:0]  rdy_meta;
    logic        hsi_req_s;
    logic        osc_ready_s;
    logic [15:0] next_freq;

    lpm_wake_sel #(.N(N)) u_wake (
        .clk                     (clk),
        .arst_n                  (arst_n),
        .gpio_pin                (gpio_pin),
        .supply_voltage_detector (supply_voltage_detector),
        .comp1_evt               (comp1_evt),
        .comp2_evt               (comp2_evt),
        .src_sel                 (src_sel),
        .line_en                 (line_en),
        .external_wake_line      (wake_lines)
    );

    // async requests from oscillator and peripherals
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hsi_meta <= 2'h0;
            rdy_meta <= 2'h0;
        end else begin
            hsi_meta <= {hsi_meta[0], hsi_req};
            rdy_meta <= {rdy_meta[0], osc_ready};
        end
    end
    assign hsi_req_s   = hsi_meta[1];
    assign osc_ready_s = rdy_meta[1];

    wire enter   = wfi | wfe;
    wire wake_ev = irq_pending | event_in;
    wire ext_wake = |wake_lines;
    wire in_run  = (state == LPM_ST_RUN);
    wire in_lpr  = (state == LPM_ST_LPRUN);
    wire to_slp  = (mode_req == LPM_REQ_SLEEP);
    wire to_lps  = (mode_req == LPM_REQ_LPSLEEP);
    wire to_stop = (mode_req == LPM_REQ_STOP);
    wire wake_done = osc_ready_s | (wake_cnt == WAKE_LAST);

    always_comb begin
        next_state = state;
        case (state)
            LPM_ST_RUN: begin
                if (enter && !wake_ev) begin
                    if (to_slp)
                        next_state = LPM_ST_SLEEP;
                    else if (to_lps || mode_req == LPM_REQ_LPRUN)
                        next_state = to_lps ? LPM_ST_LPSLEEP : LPM_ST_LPRUN;
                    else if (to_stop)
                        next_state = LPM_ST_STOP;
                end
            end
            LPM_ST_LPRUN: begin
                if (enter && !wake_ev) begin
                    if (to_slp || to_lps)
                        next_state = LPM_ST_LPSLEEP;
                    else if (to_stop)
                        next_state = LPM_ST_STOP;
                    else if (mode_req == LPM_REQ_RUN)
                        next_state = LPM_ST_RUN;
                end
            end
            LPM_ST_SLEEP: begin
                if (wake_ev)
                    next_state = LPM_ST_RUN;
            end
            LPM_ST_LPSLEEP: begin
                if (wake_ev)
                    next_state = LPM_ST_RUN;
            end
            LPM_ST_STOP: begin
                if (ext_wake)
                    next_state = LPM_ST_WAKE;
            end
            LPM_ST_WAKE: begin
                if (wake_done)
                    next_state = LPM_ST_RUN;
            end
            default: next_state = LPM_ST_RUN;
        endcase
    end

    assign next_wake_cnt = (state == LPM_ST_WAKE) ? wake_cnt + 10'h001
                                                  : 10'h000;

    wire [15:0] rng_lim = (range_sel == 2'h1) ? `LPM_F_R1_KHZ :
                          (range_sel == 2'h2) ? `LPM_F_R2_KHZ :
                                                `LPM_F_R3_KHZ;
    wire lp_next = (next_state == LPM_ST_LPRUN) |
                   (next_state == LPM_ST_LPSLEEP);
    wire [15:0] cap = lp_next ? `LPM_F_LP_KHZ : rng_lim;
    assign next_freq = (req_freq_khz > cap) ? cap : req_freq_khz;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state        <= LPM_ST_RUN;
            wake_cnt     <= 10'h000;
            cpu_freq_khz <= `LPM_RST_FREQ;
        end else begin
            state        <= next_state;
            wake_cnt     <= next_wake_cnt;
            cpu_freq_khz <= next_freq;
        end
    end

    wire st_stop = (state == LPM_ST_STOP);
    wire st_lp   = (state == LPM_ST_LPRUN) | (state == LPM_ST_LPSLEEP);
    wire st_wake = (state == LPM_ST_WAKE);

    assign pwr.cpu_clk_en  = in_run | in_lpr;
    assign pwr.core_clk_en = !st_stop & !st_wake;
    assign pwr.regulator_lp = st_lp | st_stop;
    assign pwr.retain = st_stop | st_wake;

    assign osc.pll_en = !st_stop & !st_lp & !st_wake;
    assign osc.multispeed_internal_osc_en  = !st_stop;
    assign osc.multispeed_internal_osc_low = st_lp;
    assign osc.high_speed_external_osc_en  = !st_stop & !st_lp & !st_wake;
    assign osc.high_speed_internal_osc_en  = st_stop ? hsi_req_s : !st_lp;
    assign osc.low_speed_external_osc_en = low_speed_ext_sel;
    assign osc.low_speed_internal_osc_en = !low_speed_ext_sel;

    sleep_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
        state == LPM_ST_SLEEP |-> !pwr.cpu_clk_en && pwr.core_clk_en)
        else $error("sleep clock gating wrong");
    sleep_wake_a: assert property (@(posedge clk) disable iff (!arst_n)
        state == LPM_ST_SLEEP && wake_ev |=> state == LPM_ST_RUN
        ##0 pwr.cpu_clk_en)
        else $error("sleep did not wake");
    lprun_freq_a: assert property (@(posedge clk) disable iff (!arst_n)
        st_lp |-> cpu_freq_khz <= `LPM_F_LP_KHZ && pwr.regulator_lp
        && osc.multispeed_internal_osc_low)
        else $error("low-power run over frequency");
    lpsleep_in_a: assert property (@(posedge clk) disable iff (!arst_n)
        state == LPM_ST_LPRUN && wfi && to_slp && !wake_ev
        |=> state == LPM_ST_LPSLEEP)
        else $error("low-power sleep not entered");
    lpsleep_out_a: assert property (@(posedge clk) disable iff (!arst_n)
        state == LPM_ST_LPSLEEP && wake_ev
        |=> state == LPM_ST_RUN && !pwr.regulator_lp)
        else $error("low-power sleep wake wrong");
    stop_off_a: assert property (@(posedge clk) disable iff (!arst_n)
        st_stop |-> !pwr.core_clk_en && !pwr.cpu_clk_en && !osc.pll_en
        && !osc.multispeed_internal_osc_en
        && !osc.high_speed_external_osc_en)
        else $error("stop left a clock running");
    // low-speed source and regulator in stop
    stop_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
        st_stop |-> (osc.low_speed_external_osc_en
        || osc.low_speed_internal_osc_en) && pwr.regulator_lp)
        else $error("stop low-speed or regulator wrong");
    stop_retain_a: assert property (@(posedge clk) disable iff (!arst_n)
        st_stop |-> pwr.retain)
        else $error("retention dropped in stop");
    hsi_grant_a: assert property (@(posedge clk) disable iff (!arst_n)
        st_stop && $past(hsi_req, 2) |-> osc.high_speed_internal_osc_en)
        else $error("oscillator request not granted");
    stop_wake_a: assert property (@(posedge clk) disable iff (!arst_n)
        st_stop && ext_wake |-> ##[1:872] pwr.cpu_clk_en)
        else $error("stop wake too slow");
    range_cap_a: assert property (@(posedge clk) disable iff (!arst_n)
        range_sel == 2'h3 |=> cpu_freq_khz <= `LPM_F_R3_KHZ)
        else $error("range frequency exceeded");
    mode_apply_a: assert property (@(posedge clk) disable iff (!arst_n)
        in_run && wfe && to_stop && !wake_ev |=> st_stop)
        else $error("stop request not applied");

    cov_sleep_c: cover property (@(posedge clk) disable iff (!arst_n)
        state == LPM_ST_SLEEP ##[1:20] state == LPM_ST_RUN);
    cov_stop_c: cover property (@(posedge clk) disable iff (!arst_n)
        st_stop ##1 st_wake ##[1:876] in_run);
    cov_lps_c: cover property (@(posedge clk) disable iff (!arst_n)
        state == LPM_ST_LPSLEEP ##1 in_run);
endmodule
`default_nettype wire

/* lpm_wake_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lpm_wake_src_model
#(
    parameter int N = 8
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                arst_n,
    // bench commands
    input  wire logic                fire,
    input  wire logic                prompt,
    input  wire lpm_pkg::lpm_src_e   src,
    input  wire logic [2:0]          line,
    input  wire logic [N-1:0]        noise,
    input  wire lpm_pkg::lpm_state_e state,
    // wake sources
    output logic [N-1:0]             gpio_pin,
    output logic                     supply_voltage_detector,
    output logic                     comp1_evt,
    output logic                     comp2_evt,
    output logic                     osc_ready
);
    import lpm_pkg::*;
    logic [N-1:0] sel_bit;
    logic [3:0]   wake_cnt;
    assign sel_bit = N'(1) << line;
    assign gpio_pin = (fire && src == LPM_SRC_PIN) ? (noise | sel_bit)
                                                   : (noise & ~sel_bit);
    assign supply_voltage_detector = fire && src == LPM_SRC_SVD;
    assign comp1_evt = fire && src == LPM_SRC_CMP1;
    assign comp2_evt = fire && src == LPM_SRC_CMP2;
    // oscillator reports ready only while prompt is set, once wake_cnt passes 5 in wake
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_cnt <= 4'h0;
        end else if (state != LPM_ST_WAKE) begin
            wake_cnt <= 4'h0;
        end else if (wake_cnt != 4'hF) begin
            wake_cnt <= wake_cnt + 4'h1;
        end
    end
    assign osc_ready = prompt && wake_cnt > 4'h5;
endmodule
`default_nettype wire

/* lpm_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; \
    if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module lpm_ctrl_tb_top;
    import lpm_pkg::*;
    logic             clk = 1'b0;
    logic             arst_n = 1'b0;
    lpm_mode_e        mode_req = LPM_REQ_RUN;
    logic             wfi = 1'b0;
    logic             wfe = 1'b0;
    logic             irq_pending = 1'b0;
    logic             event_in = 1'b0;
    logic [1:0]       range_sel = 2'h1;
    logic [15:0]      req_freq_khz = 16'h0000;
    logic             low_speed_ext_sel = 1'b0;
    lpm_src_e [7:0]   src_sel;
    logic [7:0]       line_en = 8'h00;
    logic             hsi_req = 1'b0;
    logic             fire = 1'b0;
    logic             prompt = 1'b0;
    lpm_src_e         src = LPM_SRC_PIN;
    logic [2:0]       ln = 3'h0;
    logic [7:0]       noise = 8'h00;
    logic [7:0]       gpio_pin;
    logic             svd;
    logic             cmp1;
    logic             cmp2;
    logic             osc_ready;
    lpm_osc_s         osc;
    lpm_pwr_s         pwr;
    lpm_state_e       state;
    logic [15:0]      cpu_freq_khz;
    logic [7:0]       wake_lines;
    logic [31:0]      seed = 32'h58BF;
    int               n_fail = 0;
    int               total_checks = 0;

    always #2 clk = ~clk;
    always @(posedge clk) noise <= seed[15:8];

    lpm_ctrl #(.N(8)) uut (.clk(clk), .arst_n(arst_n), .mode_req(mode_req),
        .wfi(wfi), .wfe(wfe), .irq_pending(irq_pending), .event_in(event_in),
        .range_sel(range_sel), .req_freq_khz(req_freq_khz),
        .low_speed_ext_sel(low_speed_ext_sel), .gpio_pin(gpio_pin),
        .supply_voltage_detector(svd), .comp1_evt(cmp1), .comp2_evt(cmp2),
        .src_sel(src_sel), .line_en(line_en), .hsi_req(hsi_req),
        .osc_ready(osc_ready), .osc(osc), .pwr(pwr), .state(state),
        .cpu_freq_khz(cpu_freq_khz), .wake_lines(wake_lines));
    lpm_wake_src_model #(.N(8)) model (.clk(clk), .arst_n(arst_n),
        .fire(fire), .prompt(prompt), .src(src), .line(ln), .noise(noise),
        .state(state), .gpio_pin(gpio_pin), .supply_voltage_detector(svd),
        .comp1_evt(cmp1), .comp2_evt(cmp2), .osc_ready(osc_ready));

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [15:0] exp_freq(input logic [1:0] rs,
                                             input logic [15:0] f,
                                             input logic lp);
        logic [15:0] cap;
        cap = lp ? 16'h0083 : rs == 2'h1 ? 16'h7D00 :
              rs == 2'h2 ? 16'h3E80 : 16'h1068;
        return f < cap ? f : cap;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_st(input lpm_state_e s, input int lim, output int c);
        c = 0;
        while (state !== s && c < lim) begin
            tick(1);
            c++;
        end
        `CHK("state", s, state)
    endtask
    // wfi or wfe held for one sampling edge only
    task automatic req(input lpm_mode_e m, input logic e, input lpm_state_e s);
        int c;
        @(posedge clk);
        mode_req <= m;
        wfi <= !e;
        wfe <= e;
        @(posedge clk);
        wfi <= 1'b0;
        wfe <= 1'b0;
        #1;
        wait_st(s, 4, c);
    endtask
    task automatic wake(input logic e);
        int c;
        @(posedge clk);
        if (e) event_in <= 1'b1;
        else irq_pending <= 1'b1;
        #1;
        wait_st(LPM_ST_RUN, 4, c);
        @(posedge clk);
        irq_pending <= 1'b0;
        event_in <= 1'b0;
        #1;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end

    initial begin
        int          c;
        logic [1:0]  rs;
        logic [15:0] f;
        for (int i = 0; i < 8; i++) src_sel[i] = LPM_SRC_PIN;
        tick(4);
        `CHK("rst_state", LPM_ST_RUN, state)
        `CHK("rst_freq", 16'h0000, cpu_freq_khz)
        @(posedge clk);
        arst_n <= 1'b1;
        // cap per range, boundary values first
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            rs = (i < 2) ? 2'h1 : seed[1:0];
            f = (i == 0) ? 16'h7D00 : (i == 1) ? 16'h7D01
                : 16'(seed[31:16] >> seed[3:0]);
            @(posedge clk);
            range_sel <= rs;
            req_freq_khz <= f;
            tick(2);
            `CHK("freq", exp_freq(rs, f, 1'b0), cpu_freq_khz)
        end
        @(posedge clk);
        range_sel <= 2'h2;
        req_freq_khz <= 16'h3E80;
        for (int e = 0; e < 2; e++) begin
            req(LPM_REQ_SLEEP, e[0], LPM_ST_SLEEP);
            `CHK("sleep_clk", 2'h1, {pwr.cpu_clk_en, pwr.core_clk_en})
            wake(e[0]);
            `CHK("cpu_en", 1'b1, pwr.cpu_clk_en)
        end
        // a pending wake must refuse the wait
        @(posedge clk);
        irq_pending <= 1'b1;
        req(LPM_REQ_SLEEP, 1'b0, LPM_ST_RUN);
        @(posedge clk);
        irq_pending <= 1'b0;
        req(LPM_REQ_LPSLEEP, 1'b1, LPM_ST_LPSLEEP);
        `CHK("lps_freq", 16'h0083, cpu_freq_khz)
        wake(1'b0);
        req(LPM_REQ_LPRUN, 1'b1, LPM_ST_LPRUN);
        tick(2);
        `CHK("msi_low", 1'b1, osc.multispeed_internal_osc_low)
        `CHK("lp_reg", 1'b1, pwr.regulator_lp)
        `CHK("lp_freq", 16'h0083, cpu_freq_khz)
        req(LPM_REQ_SLEEP, 1'b0, LPM_ST_LPSLEEP);
        `CHK("lps", 2'h1, {pwr.cpu_clk_en, pwr.regulator_lp})
        wake(1'b1);
        `CHK("reg_on", 1'b0, pwr.regulator_lp)
        tick(2);
        `CHK("freq", 16'h3E80, cpu_freq_khz)
        req(LPM_REQ_LPRUN, 1'b0, LPM_ST_LPRUN);
        req(LPM_REQ_RUN, 1'b1, LPM_ST_RUN);
        `CHK("run_freq", 16'h3E80, cpu_freq_khz)
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            @(posedge clk);
            ln <= seed[2:0];
            low_speed_ext_sel <= seed[8];
            src_sel[seed[2:0]] <= lpm_src_e'(k);
            line_en <= 8'h01 << seed[2:0];
            src <= lpm_src_e'(k);
            prompt <= k[0];
            req(LPM_REQ_STOP, k[1], LPM_ST_STOP);
            `CHK("osc_off", 4'h0, {osc.pll_en, osc.multispeed_internal_osc_en,
                osc.high_speed_external_osc_en,
                osc.high_speed_internal_osc_en})
            `CHK("clk_off", 2'h0, {pwr.cpu_clk_en, pwr.core_clk_en})
            `CHK("ls_osc", {seed[8], !seed[8]}, {osc.low_speed_external_osc_en,
                osc.low_speed_internal_osc_en})
            `CHK("reg_ret", 2'h3, {pwr.regulator_lp, pwr.retain})
            @(posedge clk);
            irq_pending <= 1'b1;
            hsi_req <= 1'b1;
            tick(4);
            `CHK("hsi_on", 1'b1, osc.high_speed_internal_osc_en)
            `CHK("irq_stop", LPM_ST_STOP, state)
            @(posedge clk);
            irq_pending <= 1'b0;
            hsi_req <= 1'b0;
            tick(4);
            `CHK("hsi_off", 1'b0, osc.high_speed_internal_osc_en)
            @(posedge clk);
            fire <= 1'b1;
            #1;
            wait_st(LPM_ST_WAKE, 6, c);
            `CHK("wake", 8'h01 << ln, wake_lines)
            wait_st(LPM_ST_RUN, 880, c);
            // four cycles to reach wake, 871 more keeps 875 from the pin
            `CHK("slow", !k[0], c > 800 && c < 872)
            `CHK("cpu_en", 1'b1, pwr.cpu_clk_en)
            @(posedge clk);
            fire <= 1'b0;
            line_en <= 8'h00;
        end
        end_of_test();
    end
endmodule
`default_nettype wire
